// [verilog/fesq_core.sv]
// erase command sequencer with status bits and lock registers
`timescale 1ns/1ps
`include "fesq_map.svh"
module fesq_core #(
   parameter int WINDOW_CYC = `FESQ_WINDOW_CYC,
   parameter int RESET_CYC = `FESQ_RESET_CYC,
   parameter int ERASE_CYC = `FESQ_ERASE_CYC,
   parameter int MAX_PASSES = `FESQ_MAX_PASSES
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] MAIN_ARRAY_SECTOR_SELECT,
   input wire logic [3:0] BOOT_SECTOR_SELECT,
   input wire logic CONTROL_REGISTER_SPACE,
   input wire logic [7:0] ARRAY_RDATA,
   input wire logic [7:0] MAIN_LOCK,
   input wire logic [3:0] BOOT_LOCK,
   input wire logic SECURITY_SET,
   input wire logic ERASE_FAIL,
   output logic [7:0] RDATA,
   output logic BUSY,
   output logic [11:0] SECTOR_ERASING,
   output logic [11:0] SECTOR_INVALID,
   output logic [7:0] ARRAY_WDATA,
   output logic ARRAY_WRITE
);
   localparam int TW = 24;
   fesq_pkg::fesq_state_t state, next_state;
   logic [2:0] step, next_step;
   logic is_bulk, next_is_bulk;
   logic [11:0] erasing, next_erasing;
   logic [11:0] invalid, next_invalid;
   logic toggle, next_toggle;
   logic err, next_err;
   logic [7:0] passes, next_passes;
   logic [7:0] rdata_q, next_rdata;
   logic tmr_load, tmr_stop, tmr_done, tmr_busy;
   logic [TW-1:0] tmr_count;
   logic [11:0] sel;
   logic [11:0] lock_vec;
   logic flash_wr, flash_rd, hit_erasing;
   assign sel = {BOOT_SECTOR_SELECT, MAIN_ARRAY_SECTOR_SELECT};
   assign lock_vec = {BOOT_LOCK, MAIN_LOCK};
   assign flash_wr = WR && (sel != '0);
   assign flash_rd = RD && (sel != '0);
   assign hit_erasing = (sel & erasing) != '0;
   fesq_timer #(.WIDTH(TW)) u_timer (
      .SYS_CLK(SYS_CLK),
      .SYS_RST(SYS_RST),
      .LOAD(tmr_load),
      .COUNT(tmr_count),
      .STOP(tmr_stop),
      .DONE(tmr_done),
      .BUSY(tmr_busy)
   );
   always_comb begin
      next_state = state;
      next_step = step;
      next_is_bulk = is_bulk;
      next_erasing = erasing;
      next_invalid = invalid;
      next_toggle = toggle;
      next_err = err;
      next_passes = passes;
      tmr_load = 1'b0;
      tmr_stop = 1'b0;
      tmr_count = '0;
      // toggle on every busy read of erasing sector
      if (flash_rd && hit_erasing && state != fesq_pkg::FESQ_READ
          && state != fesq_pkg::FESQ_SUSPENDED) begin
         next_toggle = ~toggle;
      end
      case (state)
         fesq_pkg::FESQ_READ: begin
            if (flash_wr) begin
               if (WDATA == `FESQ_D_RESET) begin
                  next_step = '0;
               end else begin
                  case (step)
                     3'd0, 3'd3: begin
                        if (ADDR == `FESQ_A_UNLOCK1 &&
                            WDATA == `FESQ_D_UNLOCK1)
                           next_step = step + 3'd1;
                        else
                           next_step = '0;
                     end
                     3'd1, 3'd4: begin
                        if (ADDR == `FESQ_A_UNLOCK2 &&
                            WDATA == `FESQ_D_UNLOCK2)
                           next_step = step + 3'd1;
                        else
                           next_step = '0;
                     end
                     3'd2: begin
                        if (ADDR == `FESQ_A_UNLOCK1 &&
                            WDATA == `FESQ_D_ERASE)
                           next_step = 3'd3;
                        else
                           next_step = '0;
                     end
                     3'd5: begin
                        next_step = '0;
                        if (WDATA == `FESQ_D_BULK &&
                            ADDR == `FESQ_A_UNLOCK1) begin
                           next_erasing = ~lock_vec;
                           next_is_bulk = 1'b1;
                           next_err = 1'b0;
                           next_passes = '0;
                           next_invalid = '0;
                           next_state = fesq_pkg::FESQ_PREPROG;
                           tmr_load = 1'b1;
                           tmr_count = TW'(ERASE_CYC);
                        end else if (WDATA == `FESQ_D_SECTOR) begin
                           next_erasing = sel & ~lock_vec;
                           next_is_bulk = 1'b0;
                           next_err = 1'b0;
                           next_passes = '0;
                           next_invalid = '0;
                           next_state = fesq_pkg::FESQ_WINDOW;
                           tmr_load = 1'b1;
                           tmr_count = TW'(WINDOW_CYC);
                        end
                     end
                     default: next_step = '0;
                  endcase
               end
            end
         end
         fesq_pkg::FESQ_WINDOW: begin
            if (flash_wr) begin
               if (WDATA == `FESQ_D_SECTOR) begin
                  next_erasing = erasing | (sel & ~lock_vec);
                  tmr_load = 1'b1;
                  tmr_count = TW'(WINDOW_CYC);
               end else if (WDATA == `FESQ_D_SUSPEND) begin
                  tmr_load = 1'b1;
                  tmr_count = TW'(`FESQ_SUSP_CYC);
                  next_state = fesq_pkg::FESQ_SUSP_WAIT;
               end else begin
                  tmr_stop = 1'b1;
                  next_erasing = '0;
                  next_state = fesq_pkg::FESQ_READ;
               end
            end else if (tmr_done) begin
               next_state = fesq_pkg::FESQ_PREPROG;
               tmr_load = 1'b1;
               tmr_count = TW'(ERASE_CYC);
            end
         end
         fesq_pkg::FESQ_PREPROG, fesq_pkg::FESQ_ERASE: begin
            // bulk ignores all; sector takes two
            if (flash_wr && !is_bulk && WDATA == `FESQ_D_SUSPEND) begin
               tmr_load = 1'b1;
               tmr_count = TW'(`FESQ_SUSP_CYC);
               next_state = fesq_pkg::FESQ_SUSP_WAIT;
            end else if (flash_wr && !is_bulk &&
                         WDATA == `FESQ_D_RESET) begin
               tmr_load = 1'b1;
               tmr_count = TW'(RESET_CYC);
               next_invalid = erasing;
               next_state = fesq_pkg::FESQ_RESETTING;
            end else if (tmr_done) begin
               if (state == fesq_pkg::FESQ_PREPROG) begin
                  // zero pass done, ones pass next
                  next_state = fesq_pkg::FESQ_ERASE;
                  tmr_load = 1'b1;
                  tmr_count = TW'(ERASE_CYC);
               end else if (ERASE_FAIL &&
                            passes < 8'(MAX_PASSES - 1)) begin
                  next_passes = passes + 8'd1;
                  tmr_load = 1'b1;
                  tmr_count = TW'(ERASE_CYC);
               end else begin
                  next_err = ERASE_FAIL;
                  next_invalid = ERASE_FAIL ? erasing : '0;
                  next_erasing = ERASE_FAIL ? erasing : '0;
                  next_state = fesq_pkg::FESQ_READ;
               end
            end
         end
         fesq_pkg::FESQ_SUSP_WAIT: begin
            // toggle stops after the short delay
            if (tmr_done)
               next_state = fesq_pkg::FESQ_SUSPENDED;
         end
         fesq_pkg::FESQ_SUSPENDED: begin
            if (flash_wr && WDATA == `FESQ_D_RESUME) begin
               next_state = fesq_pkg::FESQ_PREPROG;
               tmr_load = 1'b1;
               tmr_count = TW'(ERASE_CYC);
            end else if (flash_wr && WDATA == `FESQ_D_RESET) begin
               next_invalid = erasing;
               tmr_load = 1'b1;
               tmr_count = TW'(RESET_CYC);
               next_state = fesq_pkg::FESQ_RESETTING;
            end
         end
         fesq_pkg::FESQ_RESETTING: begin
            if (tmr_done) begin
               next_erasing = '0;
               next_step = '0;
               next_state = fesq_pkg::FESQ_READ;
            end
         end
         default: next_state = fesq_pkg::FESQ_READ;
      endcase
   end
   always_comb begin
      next_rdata = rdata_q;
      if (RD && CONTROL_REGISTER_SPACE) begin
         // main lock bits; boot bits and flag
         if (ADDR[7:0] == `FESQ_REG_MAIN_LOCK)
            next_rdata = MAIN_LOCK;
         else if (ADDR[7:0] == `FESQ_REG_SEC_LOCK)
            next_rdata = {SECURITY_SET, 3'b000, BOOT_LOCK};
         else
            next_rdata = '0;
      end else if (RD && (sel != '0)) begin
         if (hit_erasing && state != fesq_pkg::FESQ_READ &&
             state != fesq_pkg::FESQ_SUSPENDED) begin
            next_rdata = '0;
            next_rdata[`FESQ_BIT_POLL] = 1'b0;
            next_rdata[`FESQ_BIT_TOGGLE] = next_toggle;
            next_rdata[`FESQ_BIT_ERR] = err;
            next_rdata[`FESQ_BIT_WINDOW] =
               (state != fesq_pkg::FESQ_WINDOW);
         end else if ((sel & (erasing | invalid)) != '0) begin
            // erasing or invalid sector reads zero byte plus error bit
            next_rdata = `FESQ_BYTE_ZERO;
            next_rdata[`FESQ_BIT_ERR] = err;
         end else begin
            next_rdata = ARRAY_RDATA;
         end
      end
   end
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= fesq_pkg::FESQ_READ;
         step <= '0;
         is_bulk <= 1'b0;
         erasing <= '0;
         invalid <= '0;
         toggle <= 1'b0;
         err <= 1'b0;
         passes <= '0;
         rdata_q <= '0;
      end else begin
         state <= next_state;
         step <= next_step;
         is_bulk <= next_is_bulk;
         erasing <= next_erasing;
         invalid <= next_invalid;
         toggle <= next_toggle;
         err <= next_err;
         passes <= next_passes;
         rdata_q <= next_rdata;
      end
   end
   assign RDATA = rdata_q;
   assign BUSY = (state != fesq_pkg::FESQ_READ) &&
                 (state != fesq_pkg::FESQ_SUSPENDED);
   assign SECTOR_ERASING = erasing;
   assign SECTOR_INVALID = invalid;
   // zero pass then ones pass data
   assign ARRAY_WDATA = (state == fesq_pkg::FESQ_PREPROG) ?
                        `FESQ_BYTE_ZERO : `FESQ_BYTE_ONES;
   assign ARRAY_WRITE = (state == fesq_pkg::FESQ_PREPROG) ||
                        (state == fesq_pkg::FESQ_ERASE);
   a_bulk_ignore: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state == fesq_pkg::FESQ_ERASE && is_bulk && !tmr_done) |=>
      state == fesq_pkg::FESQ_ERASE) else $error("bulk left early");
   a_window_abort: assert property (@(posedge SYS_CLK)
      disable iff (SYS_RST)
      (state == fesq_pkg::FESQ_WINDOW && flash_wr &&
       WDATA != `FESQ_D_SECTOR && WDATA != `FESQ_D_SUSPEND) |=>
      state == fesq_pkg::FESQ_READ && erasing == '0)
      else $error("window not aborted");
   a_window_timer: assert property (@(posedge SYS_CLK)
      disable iff (SYS_RST)
      state == fesq_pkg::FESQ_WINDOW |-> tmr_busy || tmr_done)
      else $error("window timer idle");
   a_susp_take: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state == fesq_pkg::FESQ_WINDOW && flash_wr &&
       WDATA == `FESQ_D_SUSPEND) |=>
      state == fesq_pkg::FESQ_SUSP_WAIT ##[1:20]
      state == fesq_pkg::FESQ_SUSPENDED)
      else $error("suspend not reached");
   a_susp_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state == fesq_pkg::FESQ_SUSPENDED && flash_wr &&
       WDATA != `FESQ_D_RESUME && WDATA != `FESQ_D_RESET) |=>
      state == fesq_pkg::FESQ_SUSPENDED)
      else $error("suspend left wrongly");
   a_resume_go: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state == fesq_pkg::FESQ_SUSPENDED && flash_wr &&
       WDATA == `FESQ_D_RESUME) |=> state == fesq_pkg::FESQ_PREPROG)
      else $error("resume ignored");
   a_reset_inval: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state == fesq_pkg::FESQ_SUSPENDED && flash_wr &&
       WDATA == `FESQ_D_RESET) |=> invalid == $past(erasing))
      else $error("sector not invalid");
   a_lock_skip: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (erasing & lock_vec) == '0)
      else $error("locked sector erased");
   a_toggle_flip: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (flash_rd && hit_erasing && BUSY) |=> toggle != $past(toggle))
      else $error("toggle stuck");
   c_bulk: cover property (@(posedge SYS_CLK)
      state == fesq_pkg::FESQ_ERASE && is_bulk);
   c_window_done: cover property (@(posedge SYS_CLK)
      state == fesq_pkg::FESQ_WINDOW && tmr_done);
   c_suspended: cover property (@(posedge SYS_CLK)
      state == fesq_pkg::FESQ_SUSPENDED);
   c_error: cover property (@(posedge SYS_CLK) err);
endmodule

// [verilog/fesq_map.svh]
// offsets, fields, command codes and timing counts of the erase sequencer
`ifndef FESQ_MAP_SVH
`define FESQ_MAP_SVH
`define FESQ_CLK_MHZ 100
`define FESQ_WINDOW_US 100
`define FESQ_WINDOW_CYC (`FESQ_WINDOW_US * `FESQ_CLK_MHZ)
`define FESQ_SUSP_MIN_NS 100
`define FESQ_SUSP_MAX_US 15
`define FESQ_SUSP_CYC ((`FESQ_SUSP_MIN_NS + 9) / 10)
`define FESQ_RESET_MS 2
`define FESQ_RESET_CYC (`FESQ_RESET_MS * 1000 * `FESQ_CLK_MHZ)
`define FESQ_ERASE_CYC 50000
`define FESQ_MAX_PASSES 8
`define FESQ_REG_MAIN_LOCK 8'hC0
`define FESQ_REG_SEC_LOCK 8'hC2
`define FESQ_BIT_POLL 7
`define FESQ_BIT_TOGGLE 6
`define FESQ_BIT_ERR 5
`define FESQ_BIT_WINDOW 3
`define FESQ_SEC_FLAG_BIT 7
`define FESQ_D_UNLOCK1 8'hAA
`define FESQ_D_UNLOCK2 8'h55
`define FESQ_D_ERASE 8'h80
`define FESQ_D_BULK 8'h10
`define FESQ_D_SECTOR 8'h30
`define FESQ_D_SUSPEND 8'hB0
`define FESQ_D_RESUME 8'h30
`define FESQ_D_RESET 8'hF0
`define FESQ_A_UNLOCK1 12'h555
`define FESQ_A_UNLOCK2 12'hAAA
`define FESQ_BYTE_ZERO 8'h00
`define FESQ_BYTE_ONES 8'hFF
`endif

// [verilog/fesq_pkg.sv]
// types of the erase sequencer
package fesq_pkg;
   typedef enum logic [3:0] {
      FESQ_READ,
      FESQ_WINDOW,
      FESQ_PREPROG,
      FESQ_ERASE,
      FESQ_SUSP_WAIT,
      FESQ_SUSPENDED,
      FESQ_RESETTING
   } fesq_state_t;
endpackage

// [verilog/fesq_timer.sv]
// loadable down-counter giving a one-cycle done pulse
`timescale 1ns/1ps
module fesq_timer #(
   parameter int WIDTH = 24
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic LOAD,
   input wire logic [WIDTH-1:0] COUNT,
   input wire logic STOP,
   output logic DONE,
   output logic BUSY
);
   logic [WIDTH-1:0] cnt;
   logic [WIDTH-1:0] next_cnt;
   logic next_done;
   always_comb begin
      next_cnt = cnt;
      next_done = 1'b0;
      if (STOP) begin
         next_cnt = '0;
      end else if (LOAD) begin
         next_cnt = COUNT;
      end else if (cnt == WIDTH'(1)) begin
         next_cnt = '0;
         next_done = 1'b1;
      end else if (cnt != '0) begin
         next_cnt = cnt - WIDTH'(1);
      end
   end
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt <= '0;
         DONE <= 1'b0;
      end else begin
         cnt <= next_cnt;
         DONE <= next_done;
      end
   end
   assign BUSY = (cnt != '0);
endmodule

// [bench/fesq_host.sv]
// microcontroller bus model issuing instruction writes and reads
`timescale 1ns/1ps
module fesq_host (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output logic [11:0] addr,
   output logic [7:0] wdata,
   output logic wr_s,
   output logic rd_s,
   output logic [7:0] msel,
   output logic [3:0] bsel,
   output logic creg
);
   // host code kept off the array
   initial begin
      addr = 12'h000;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      msel = 8'h00;
      bsel = 4'h0;
      creg = 1'b0;
   end
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
         input logic [11:0] s);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      msel <= s[7:0];
      bsel <= s[11:8];
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      msel <= 8'h00;
      bsel <= 4'h0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic rd(input logic [11:0] a, input logic [11:0] s,
         input logic c, output logic [7:0] q);
      @(posedge clk);
      addr <= a;
      msel <= s[7:0];
      bsel <= s[11:8];
      creg <= c;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      msel <= 8'h00;
      bsel <= 4'h0;
      creg <= 1'b0;
      addr <= ~a;
      #1;
      q = rdata;
   endtask
endmodule

// [bench/fesq_core_tb.sv]
// self-checking bench of the erase sequencer
`timescale 1ns/1ps
module fesq_core_tb;
   logic clk;
   logic rst;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic wr_s;
   logic rd_s;
   logic [7:0] msel;
   logic [3:0] bsel;
   logic creg;
   logic [7:0] ardata;
   logic [7:0] mlock;
   logic [3:0] blk_lock;
   logic sec_set;
   logic efail;
   logic [7:0] rdata;
   logic busy;
   logic [11:0] serase;
   logic [11:0] sinv;
   logic [7:0] awdata;
   logic awrite;
   logic seen0;
   logic seen1;
   logic [7:0] q;
   logic [7:0] q2;
   int n_fail;
   int cmp_count;
   int cyc;
   int n;
   fesq_core #(.WINDOW_CYC(20), .RESET_CYC(10), .ERASE_CYC(10),
         .MAX_PASSES(8)) dut (
      .SYS_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr_s), .RD(rd_s), .MAIN_ARRAY_SECTOR_SELECT(msel),
      .BOOT_SECTOR_SELECT(bsel), .CONTROL_REGISTER_SPACE(creg),
      .ARRAY_RDATA(ardata), .MAIN_LOCK(mlock), .BOOT_LOCK(blk_lock),
      .SECURITY_SET(sec_set), .ERASE_FAIL(efail), .RDATA(rdata),
      .BUSY(busy), .SECTOR_ERASING(serase), .SECTOR_INVALID(sinv),
      .ARRAY_WDATA(awdata), .ARRAY_WRITE(awrite)
   );
   fesq_host host (
      .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr_s(wr_s), .rd_s(rd_s), .msel(msel), .bsel(bsel), .creg(creg)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // notes zero fill followed by ones fill
   always @(posedge clk) begin
      if (rst) begin
         seen0 <= 1'b0;
         seen1 <= 1'b0;
      end else if (awrite === 1'b1) begin
         if (awdata === 8'h00) seen0 <= 1'b1;
         if (awdata === 8'hFF && seen0) seen1 <= 1'b1;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("BAD %0t timeout", $time);
         wrap_up;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
         input string m);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic wt(input logic lvl, input int lim);
      n = 0;
      #1;
      while (busy !== lvl && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({7'h00, busy}, {7'h00, lvl}, "busy level");
   endtask
   task automatic do_rst;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic erase(input logic [11:0] s, input logic [7:0] d);
      host.wr(12'h555, 8'hAA, s);
      host.wr(12'hAAA, 8'h55, s);
      host.wr(12'h555, 8'h80, s);
      host.wr(12'h555, 8'hAA, s);
      host.wr(12'hAAA, 8'h55, s);
      host.wr((d == 8'h10) ? 12'h555 : 12'h000, d, s);
   endtask
   task automatic t_regs;
      do_rst;
      mlock <= 8'hA5;
      blk_lock <= 4'h9;
      sec_set <= 1'b1;
      host.rd(12'h0C0, 12'h000, 1'b1, q);
      chk(q, 8'hA5, "main lock");
      host.rd(12'h0C2, 12'h000, 1'b1, q);
      chk(q, 8'h89, "boot lock");
      host.rd(12'h0C4, 12'h000, 1'b1, q);
      chk(q, 8'h00, "unmapped");
      mlock <= 8'h00;
      blk_lock <= 4'h0;
      sec_set <= 1'b0;
      $display("regs done");
   endtask
   task automatic t_bulk;
      do_rst;
      ardata <= 8'h3C;
      erase(12'h001, 8'h10);
      wt(1'b1, 4);
      host.rd(12'h000, 12'h001, 1'b0, q);
      host.rd(12'h000, 12'h001, 1'b0, q2);
      chk(q[6] ^ q2[6], 1'b1, "toggle");
      chk(q[7], 1'b0, "poll");
      host.wr(12'h000, 8'hB0, 12'h001);
      host.wr(12'h000, 8'hF0, 12'h001);
      #1;
      chk(busy, 1'b1, "bulk ignores");
      chk(sinv[7:0], 8'h00, "bulk ignores reset");
      wt(1'b0, 600);
      chk({seen0, seen1}, 2'b11, "fill order");
      host.rd(12'h000, 12'h001, 1'b0, q);
      host.rd(12'h000, 12'h001, 1'b0, q2);
      chk(q, 8'h3C, "array read");
      chk(q2, 8'h3C, "array read");
      $display("bulk done");
   endtask
   task automatic t_abort;
      do_rst;
      host.wr(12'h555, 8'hAA, 12'h001);
      host.wr(12'hAAA, 8'h55, 12'h001);
      host.wr(12'h555, 8'h81, 12'h001);
      host.wr(12'h555, 8'hAA, 12'h001);
      host.wr(12'hAAA, 8'h55, 12'h001);
      host.wr(12'h555, 8'h10, 12'h001);
      repeat (3) @(posedge clk);
      chk(busy, 1'b0, "abort");
      $display("abort done");
   endtask
   task automatic t_window;
      do_rst;
      erase(12'h004, 8'h30);
      repeat (10) @(posedge clk);
      host.wr(12'h000, 8'h30, 12'h020);
      repeat (12) @(posedge clk);
      host.rd(12'h000, 12'h004, 1'b0, q);
      chk(q[3], 1'b0, "window restart");
      chk(serase[7:0], 8'h24, "two sectors");
      repeat (10) @(posedge clk);
      host.rd(12'h000, 12'h004, 1'b0, q);
      chk(q[3], 1'b1, "window over");
      host.wr(12'h000, 8'h80, 12'h004);
      #1;
      chk(busy, 1'b1, "erase ignores");
      chk(serase[7:0], 8'h24, "erase kept");
      wt(1'b0, 800);
      $display("window done");
   endtask
   task automatic t_cancel;
      do_rst;
      erase(12'h004, 8'h30);
      host.wr(12'h555, 8'hAA, 12'h004);
      wt(1'b0, 5);
      erase(12'h004, 8'h30);
      host.wr(12'h000, 8'hB0, 12'h004);
      wt(1'b0, 30);
      repeat (40) @(posedge clk);
      chk(busy, 1'b0, "window ended");
      host.wr(12'h000, 8'h30, 12'h004);
      host.rd(12'h000, 12'h004, 1'b0, q);
      chk(q[3], 1'b1, "no window");
      chk(busy, 1'b1, "resumed");
      wt(1'b0, 600);
      $display("cancel done");
   endtask
   task automatic t_suspend;
      do_rst;
      ardata <= 8'h5A;
      erase(12'h004, 8'h30);
      repeat (32) @(posedge clk);
      host.wr(12'h000, 8'h80, 12'h004);
      #1;
      chk(busy, 1'b1, "erase ignores");
      host.wr(12'h000, 8'hB0, 12'h004);
      wt(1'b0, 1600);
      chk(n >= 10 && n <= 1500, 1'b1, "suspend delay");
      host.rd(12'h000, 12'h004, 1'b0, q);
      host.rd(12'h000, 12'h004, 1'b0, q2);
      chk(q[6], q2[6], "toggle stopped");
      host.rd(12'h000, 12'h020, 1'b0, q);
      chk(q, 8'h5A, "other sector");
      host.wr(12'h000, 8'h80, 12'h020);
      chk(busy, 1'b0, "suspend refuses");
      host.wr(12'h000, 8'h30, 12'h004);
      wt(1'b1, 4);
      host.wr(12'h000, 8'hB0, 12'h004);
      wt(1'b0, 40);
      host.wr(12'h000, 8'hF0, 12'h004);
      wt(1'b1, 3);
      wt(1'b0, 40);
      chk(sinv[2], 1'b1, "sector invalid");
      $display("suspend done");
   endtask
   task automatic t_fail;
      do_rst;
      efail <= 1'b1;
      erase(12'h004, 8'h30);
      q = 8'h00;
      n = 0;
      while (q[5] !== 1'b1 && n < 400) begin
         host.rd(12'h000, 12'h004, 1'b0, q);
         n++;
      end
      chk(q[5], 1'b1, "erase error");
      efail <= 1'b0;
      $display("fail done");
   endtask
   task automatic t_protect;
      do_rst;
      mlock <= 8'h02;
      erase(12'h002, 8'h30);
      repeat (3) @(posedge clk);
      chk(serase[1], 1'b0, "locked sector");
      wt(1'b0, 200);
      mlock <= 8'h00;
      $display("protect done");
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      ardata = 8'h00;
      mlock = 8'h00;
      blk_lock = 4'h0;
      sec_set = 1'b0;
      efail = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_bulk;
      t_abort;
      t_window;
      t_cancel;
      t_suspend;
      t_fail;
      t_protect;
      wrap_up;
   end
endmodule
